// file: sfim_pkg.sv
// package of offsets, field positions and reset values for the fault interrupt mask block
package sfim_pkg;
	// register word offsets (byte addresses)
	localparam logic [7:0] SFIM_RAW_OFS = 8'h00;
	localparam logic [7:0] SFIM_ENABLE_OFS = 8'h04;
	localparam logic [7:0] SFIM_MASKED_OFS = 8'h08;
	localparam logic [7:0] SFIM_CLEAR_OFS = 8'h0C;
	// field positions within each fault register
	localparam int SFIM_PLL_FAULT_BIT = 0;
	localparam int SFIM_BROWNOUT_BIT = 1;
	localparam int SFIM_REGULATOR_BIT = 2;
	localparam int SFIM_MAIN_OSC_BIT = 3;
	localparam int SFIM_INT_OSC_BIT = 4;
	localparam int SFIM_NUM_FAULTS = 5;
	// reset values
	localparam logic [4:0] SFIM_ENABLE_RST = 5'h00;
	localparam logic [4:0] SFIM_RAW_RST = 5'h00;
	localparam logic [31:0] SFIM_UNMAPPED_DATA = 32'h00000000;
endpackage : sfim_pkg

// file: sfim_flag.sv
// one sticky raw fault flag with its three-stage input synchroniser
`timescale 1ns/100ps
module sfim_flag (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// fault detector level from outside the clock domain
	input wire logic fault_i,
	// software clear pulse
	input wire logic clear_i,
	// sticky flag
	output logic flag_o
);
	logic [2:0] sync;
	logic [2:0] next_sync;
	logic seen;
	logic next_seen;
	logic flag;
	logic next_flag;
	logic event_set;

	// a change counts once the second and third stages agree
	always_comb begin
		next_sync = {sync[1:0], fault_i};
		if (sync[2] == sync[1]) begin
			next_seen = sync[1];
		end else begin
			next_seen = seen;
		end
		event_set = next_seen & ~seen;
		// a detector edge in the same cycle as a clear keeps the flag set
		next_flag = event_set | (flag & ~clear_i);
	end

	// registers only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync <= 3'h0;
			seen <= 1'b0;
			flag <= 1'b0;
		end else begin
			sync <= next_sync;
			seen <= next_seen;
			flag <= next_flag;
		end
	end

	assign flag_o = flag;
endmodule : sfim_flag

// file: sfim_fault_irq.sv
// fault interrupt mask block: raw flags, enable register, masked status and interrupt line
//
// Contract
// - main oscillator fault gated by enable bit 3
// - regulator unregulated fault gated by bit 2
// - brown-out fault gated by enable bit 1
// - PLL fault gated by enable bit 0
// - enable bits read/write, cleared by reset
// - masked equals raw and enable; W1C clears raw
`timescale 1ns/100ps
module sfim_fault_irq
	import sfim_pkg::*;
#(
	parameter int NUM_FAULTS = sfim_pkg::SFIM_NUM_FAULTS
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// classic wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// fault detector levels, asynchronous
	input wire logic int_osc_fault_i,
	input wire logic main_osc_fault_i,
	input wire logic regulator_unreg_i,
	input wire logic brownout_i,
	input wire logic pll_fault_i,
	// combined fault interrupt to the processor
	output logic irq_o
);
	import sfim_pkg::*;

	// detector levels gathered by field position
	logic [NUM_FAULTS-1:0] fault_in;
	// sticky raw flags, one per fault
	logic [NUM_FAULTS-1:0] raw_fault_status;
	// one-cycle clear strobes, one per raw flag
	logic [NUM_FAULTS-1:0] clear_pulse;
	// software enable word and its next value
	logic [NUM_FAULTS-1:0] fault_interrupt_enable;
	logic [NUM_FAULTS-1:0] next_enable;
	// raw flags gated by their enable bits
	logic [NUM_FAULTS-1:0] masked_status;
	// read data word and its next value
	logic [31:0] rd_data;
	logic [31:0] next_rd_data;
	// acknowledge and its next value
	logic ack;
	logic next_ack;
	// request qualifiers
	logic bus_req;
	logic wr_take;
	logic rd_take;
	// address decode
	logic hit_raw;
	logic hit_enable;
	logic hit_masked;
	logic hit_clear;
	// per-fault interrupt requests
	logic pll_fault_hit;
	logic brownout_hit;
	logic regulator_hit;
	logic main_osc_hit;
	logic int_osc_hit;
	// interrupt line and its next value
	logic irq;
	logic next_irq;

	// gather detector inputs by field position
	always_comb begin
		// positions above the five faults stay low
		fault_in = '0;
		fault_in[SFIM_PLL_FAULT_BIT] = pll_fault_i;
		fault_in[SFIM_BROWNOUT_BIT] = brownout_i;
		fault_in[SFIM_REGULATOR_BIT] = regulator_unreg_i;
		fault_in[SFIM_MAIN_OSC_BIT] = main_osc_fault_i;
		fault_in[SFIM_INT_OSC_BIT] = int_osc_fault_i;
	end

	// address decode; the raw word ignores writes and changes only through its flags
	assign hit_raw = (adr_i == SFIM_RAW_OFS);
	assign hit_enable = (adr_i == SFIM_ENABLE_OFS);
	assign hit_masked = (adr_i == SFIM_MASKED_OFS);
	assign hit_clear = (adr_i == SFIM_CLEAR_OFS);

	// a request is taken once; ack is low in the cycle after it was high
	assign bus_req = cyc_i & stb_i & ~ack;
	// only byte lane 0 holds fields, so a write without it is acked and changes nothing
	assign wr_take = bus_req & we_i & sel_i[0];
	assign rd_take = bus_req & ~we_i;

	always_comb begin
		clear_pulse = '0;
		if (wr_take && (hit_masked || hit_clear)) begin
			// both words clear, so software need not read before clearing
			clear_pulse = dat_i[NUM_FAULTS-1:0];
		end
	end

	// one sticky flag per fault, each with its own synchroniser
	// a detector edge reaches its raw flag four clocks after it arrives
	genvar g;
	generate
		for (g = 0; g < NUM_FAULTS; g++) begin : g_flag
			sfim_flag u_flag (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.fault_i(fault_in[g]),
				.clear_i(clear_pulse[g]),
				.flag_o(raw_fault_status[g])
			);
		end
	endgenerate

	// each gate lets one fault reach the interrupt line only while enabled
	// PLL fault gate
	assign pll_fault_hit = raw_fault_status[SFIM_PLL_FAULT_BIT]
		& fault_interrupt_enable[SFIM_PLL_FAULT_BIT];

	assign brownout_hit = raw_fault_status[SFIM_BROWNOUT_BIT]
		& fault_interrupt_enable[SFIM_BROWNOUT_BIT];

	assign regulator_hit = raw_fault_status[SFIM_REGULATOR_BIT]
		& fault_interrupt_enable[SFIM_REGULATOR_BIT];

	assign main_osc_hit = raw_fault_status[SFIM_MAIN_OSC_BIT]
		& fault_interrupt_enable[SFIM_MAIN_OSC_BIT];

	assign int_osc_hit = raw_fault_status[SFIM_INT_OSC_BIT]
		& fault_interrupt_enable[SFIM_INT_OSC_BIT];

	// masked word built bit for bit from the gates
	always_comb begin
		// bits above the five faults read zero
		masked_status = '0;
		masked_status[SFIM_PLL_FAULT_BIT] = pll_fault_hit;
		masked_status[SFIM_BROWNOUT_BIT] = brownout_hit;
		masked_status[SFIM_REGULATOR_BIT] = regulator_hit;
		masked_status[SFIM_MAIN_OSC_BIT] = main_osc_hit;
		masked_status[SFIM_INT_OSC_BIT] = int_osc_hit;
	end

	always_comb begin
		next_enable = fault_interrupt_enable;
		// a write without byte lane 0 never reaches this branch
		if (wr_take && hit_enable) begin
			next_enable = dat_i[NUM_FAULTS-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fault_interrupt_enable <= NUM_FAULTS'(SFIM_ENABLE_RST);
		end else begin
			fault_interrupt_enable <= next_enable;
		end
	end

	// read mux; unmapped words read zero and still get an ack
	always_comb begin
		next_rd_data = rd_data;
		if (rd_take) begin
			if (hit_raw) begin
				next_rd_data = {{(32-NUM_FAULTS){1'b0}}, raw_fault_status};
			end else if (hit_enable) begin
				next_rd_data = {{(32-NUM_FAULTS){1'b0}}, fault_interrupt_enable};
			end else if (hit_masked) begin
				next_rd_data = {{(32-NUM_FAULTS){1'b0}}, masked_status};
			end else begin
				// the clear word is write only and reads zero like a hole
				next_rd_data = SFIM_UNMAPPED_DATA;
			end
		end
		// one-cycle ack in the cycle after the request is taken
		next_ack = bus_req;
	end

	// bus registers; read data holds until the next read
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_data <= SFIM_UNMAPPED_DATA;
			ack <= 1'b0;
		end else begin
			rd_data <= next_rd_data;
			ack <= next_ack;
		end
	end

	// registered irq costs a cycle but keeps the line glitch free
	always_comb begin
		// any enabled raw flag holds the line until software clears it
		next_irq = pll_fault_hit | brownout_hit | regulator_hit | main_osc_hit | int_osc_hit;
	end

	// interrupt line register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq <= 1'b0;
		end else begin
			irq <= next_irq;
		end
	end

	// outputs straight from flip-flops
	assign dat_o = rd_data;
	assign ack_o = ack;
	assign irq_o = irq;
endmodule : sfim_fault_irq

// file: sfim_chk.sv
// port checker for the fault interrupt mask block
`timescale 1ns/100ps
module sfim_chk (
	// watched ports
	input logic clk_i, rst_i, we_i, ack_o, irq_o, pll_fault_i, brownout_i,
	input logic regulator_unreg_i, main_osc_fault_i, int_osc_fault_i,
	input logic [7:0] adr_i,
	input logic [3:0] sel_i,
	input logic [31:0] dat_i
);
	logic [4:0] en, next_en;
	logic wr;
	// shadow of the enable word; a write lands at its ack edge
	assign wr = ack_o && we_i && sel_i[0];
	always_comb next_en = (wr && adr_i == 8'h04) ? dat_i[4:0] : en;
	always_ff @(posedge clk_i) en <= rst_i ? 5'h00 : next_en;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	irq_rst_a: assert property ($fell(rst_i) |-> !irq_o) else $error("rst");
	pll_irq_a: assert property ($rose(pll_fault_i) && en[0] |-> ##[3:6] irq_o) else $error("p");
	bo_irq_a: assert property ($rose(brownout_i) && en[1] |-> ##[3:6] irq_o) else $error("b");
	reg_irq_a: assert property ($rose(regulator_unreg_i) && en[2] |-> ##[3:6] irq_o) else $error("r");
	mo_irq_a: assert property ($rose(main_osc_fault_i) && en[3] |-> ##[3:6] irq_o) else $error("m");
	io_irq_a: assert property ($rose(int_osc_fault_i) && en[4] |-> ##[3:6] irq_o) else $error("i");
	mask_off_a: assert property ((en == 5'h00) [*2] |-> !irq_o) else $error("mask");
	clear_all_a: assert property (wr && adr_i == 8'h08 && dat_i[4:0] == 5'h1F |-> ##2 !irq_o) else $error("clr");
	cover property ($rose(irq_o));
	cover property ($fell(irq_o));
	cover property (wr && adr_i == 8'h0C);
endmodule : sfim_chk
bind sfim_fault_irq sfim_chk i_sfim_chk (.*);

// file: test_sfim_fault_irq.sv
// bench for the fault interrupt mask block
`timescale 1ns/100ps
module test_sfim_fault_irq;
	import sfim_pkg::*;
	logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o, irq_o;
	logic [7:0] adr_i = 8'h00;
	logic [3:0] sel_i = 4'hF;
	logic [31:0] dat_i = 32'h0, dat_o, rd;
	logic [4:0] f = 5'h00;
	int num_errors = 0, checks_done = 0;
	sfim_fault_irq i_sfim_fault_irq (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.cyc_i(cyc_i),
		.stb_i(stb_i),
		.we_i(we_i),
		.adr_i(adr_i),
		.sel_i(sel_i),
		.dat_i(dat_i),
		.dat_o(dat_o),
		.ack_o(ack_o),
		.int_osc_fault_i(f[4]),
		.main_osc_fault_i(f[3]),
		.regulator_unreg_i(f[2]),
		.brownout_i(f[1]),
		.pll_fault_i(f[0]),
		.irq_o(irq_o)
	);
	initial forever #5 clk_i = ~clk_i;
	task summarize;
		if (num_errors == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : summarize
	task chk(input logic [31:0] s, e);
		checks_done++;
		if (s !== e) num_errors++;
		if (s !== e) $display("FAIL %0t got %h want %h", $time, s, e);
	endtask : chk
	// one bus cycle; ack is read before the edge lands, a stuck slave ends the run
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		{cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
		do @(posedge clk_i); while (ack_o !== 1'b1 && ++n < 20);
		if (n >= 20) num_errors++;
		if (n >= 20) summarize();
		rd = dat_o;
		{cyc_i, stb_i} <= 2'b00;
		@(posedge clk_i);
	endtask : wb
	// long enough to cross the input synchroniser
	task pulse(input int k);
		f[k] <= 1'b1;
		repeat (8) @(posedge clk_i);
		f[k] <= 1'b0;
	endtask : pulse
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(0, SFIM_ENABLE_OFS, 0);
		chk(rd, 0);
		wb(1, SFIM_ENABLE_OFS, 32'hFFFFFFFF);
		wb(0, SFIM_ENABLE_OFS, 0);
		chk(rd, 32'h1F);
		// byte lane 0 off: the write is acked but changes nothing
		sel_i <= 4'hE;
		wb(1, SFIM_ENABLE_OFS, 0);
		sel_i <= 4'hF;
		wb(0, SFIM_ENABLE_OFS, 0);
		chk(rd, 32'h1F);
		for (int k = 0; k < 5; k++) begin
			wb(1, SFIM_ENABLE_OFS, 0);
			pulse(k);
			chk(irq_o, 0);
			wb(1, SFIM_ENABLE_OFS, 1 << k);
			@(posedge clk_i);
			chk(irq_o, 1);
			wb(0, SFIM_MASKED_OFS, 0);
			chk(rd, 1 << k);
			wb(1, SFIM_MASKED_OFS, 32'h1F);
			wb(0, SFIM_RAW_OFS, 0);
			chk(rd, 0);
			pulse(k);
			chk(irq_o, 1);
			wb(1, SFIM_CLEAR_OFS, 32'h1F);
			@(posedge clk_i);
			chk(irq_o, 0);
		end
		// a reset in mid-run clears an enable word that software had set
		wb(1, SFIM_ENABLE_OFS, 32'h1F);
		pulse(0);
		chk(irq_o, 1);
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		chk(irq_o, 0);
		wb(0, SFIM_ENABLE_OFS, 0);
		chk(rd, 0);
		wb(0, SFIM_RAW_OFS, 0);
		chk(rd, 0);
		// a fault after reset sets its raw flag but raises no interrupt
		pulse(1);
		chk(irq_o, 0);
		// the raw word ignores writes; the clear word reads zero
		wb(1, SFIM_RAW_OFS, 0);
		wb(0, SFIM_RAW_OFS, 0);
		chk(rd, 32'h2);
		wb(0, SFIM_CLEAR_OFS, 0);
		chk(rd, 0);
		summarize();
	end
endmodule : test_sfim_fault_irq
